// [scs_analog_model.sv]
/*
  Analog side of the converter: held sample and comparator.
  Assumes each trial code is judged within the same cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module scs_analog_model (
  input wire logic [15:0] vin_in,
  input wire logic [15:0] dac_code_in,
  output logic comp_out
);
  // Keep the trial bit while the sample reaches the trial level
  assign comp_out = (vin_in >= dac_code_in);
endmodule
`default_nettype wire

// [scs_buffer.sv]
/*
  Small FIFO holding finished results.
  Assumes the writer stalls while in_ready_out is low.
*/
`timescale 1ns/100ps
`default_nettype none
module scs_buffer #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 2
)(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } scs_buf_regs_t;
  scs_buf_regs_t r;
  scs_buf_regs_t next_r;
  logic wr_en;
  logic rd_en;
  assign in_ready_out = (r.cnt != FULL);
  assign out_valid_out = (r.cnt != '0);
  assign out_data_out = r.mem[r.rd];
  assign wr_en = in_valid_in & in_ready_out;
  assign rd_en = out_valid_out & out_ready_in;
  always_comb
  begin
    next_r = r;
    if (wr_en)
    begin
      next_r.mem[r.wr] = in_data_in;
      next_r.wr = (r.wr == LAST) ? '0 : r.wr + 1'b1;
    end
    if (rd_en)
      next_r.rd = (r.rd == LAST) ? '0 : r.rd + 1'b1;
    if (wr_en && !rd_en)
      next_r.cnt = r.cnt + 1'b1;
    else if (rd_en && !wr_en)
      next_r.cnt = r.cnt - 1'b1;
    if (!ce_in)
      next_r = r;
  end
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      r <= '0;
    else
      r <= next_r;
  end
endmodule
`default_nettype wire

// [scs_pkg.sv]
/*
  Shared constants and types of the conversion sequencer.
  Assumes a 100 MHz system clock; all counts are derived here.
*/
`default_nettype none
package scs_pkg;
  // ****************************************
  // Resolution and codes
  // ****************************************
  localparam int RES_BITS = 16;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;
  localparam logic [15:0] CODE_FULL = 16'hFFFF;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int FAST_PERIOD_NS = 400;
  localparam int NORM_PERIOD_NS = 500;
  localparam int STEP_NS = 20;
  localparam int WAKE_NS = 60;
  localparam int FAST_CYC = (FAST_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NORM_CYC = (NORM_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_CYC = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam int BUF_DEPTH = 2;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0]
  {
    ST_ACQ = 2'b00,
    ST_WAKE = 2'b01,
    ST_CONV = 2'b11,
    ST_DONE = 2'b10
  } scs_state_t;
  typedef struct packed {
    logic [15:0] code;
    logic first;
  } scs_result_t;
  typedef struct packed {
    scs_state_t st;
    logic start_d;
    logic fast;
    logic first;
    logic over;
    logic under;
    logic [15:0] trial;
    logic [15:0] mask;
    logic [CNT_W-1:0] step_cnt;
    logic [CNT_W-1:0] rate_cnt;
  } scs_regs_t;
endpackage
`default_nettype wire

// [scs_sequencer.sv]
/*
  Successive-approximation conversion sequencer with result buffer.
  Assumes synchronous inputs, a comparator that answers within one
  clock, and range detectors sampled at the start of conversion.
*/
`timescale 1ns/100ps
`default_nettype none
module scs_sequencer #(
  parameter int STEP_CYC = scs_pkg::STEP_CYC,
  parameter int WAKE_CYC = scs_pkg::WAKE_CYC,
  parameter int FAST_CYC = scs_pkg::FAST_CYC,
  parameter int NORM_CYC = scs_pkg::NORM_CYC,
  parameter int BUF_DEPTH = scs_pkg::BUF_DEPTH
)(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic convert_start_in,
  input wire logic fast_mode_in,
  input wire logic comp_in,
  input wire logic over_range_in,
  input wire logic under_range_in,
  input wire logic result_ready_in,
  output logic busy_out,
  output logic power_up_out,
  output logic track_out,
  output logic [15:0] dac_code_out,
  output logic result_valid_out,
  output scs_pkg::scs_result_t result_out
);
  localparam logic [scs_pkg::CNT_W-1:0] STEP_LD = scs_pkg::CNT_W'(STEP_CYC - 1);
  localparam logic [scs_pkg::CNT_W-1:0] WAKE_LD = scs_pkg::CNT_W'(WAKE_CYC - 1);
  localparam logic [scs_pkg::CNT_W-1:0] FAST_LD = scs_pkg::CNT_W'(FAST_CYC - 1);
  localparam logic [scs_pkg::CNT_W-1:0] NORM_LD = scs_pkg::CNT_W'(NORM_CYC - 1);
  scs_pkg::scs_regs_t r;
  scs_pkg::scs_regs_t next_r;
  scs_pkg::scs_result_t push_data;
  logic start_edge;
  logic accept;
  logic push;
  logic buf_ready;
  logic step_end;
  logic [15:0] kept;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // ****************************************
  // Sequencing
  // ****************************************
  assign start_edge = convert_start_in & ~r.start_d;
  assign accept = (r.st == scs_pkg::ST_ACQ) & start_edge & (r.rate_cnt == '0);
  assign step_end = (r.step_cnt == '0);
  assign kept = comp_in ? r.trial : (r.trial & ~r.mask);
  always_comb
  begin
    next_r = r;
    push = 1'b0;
    next_r.start_d = convert_start_in;
    if (r.rate_cnt != '0)
      next_r.rate_cnt = r.rate_cnt - 1'b1;
    case (r.st)
      scs_pkg::ST_ACQ:
      begin
        if (accept)
        begin
          next_r.rate_cnt = fast_mode_in ? FAST_LD : NORM_LD;
          next_r.fast = fast_mode_in;
          next_r.over = over_range_in;
          next_r.under = under_range_in;
          next_r.trial = scs_pkg::CODE_MID;
          next_r.mask = scs_pkg::CODE_MID;
          next_r.step_cnt = fast_mode_in ? STEP_LD : WAKE_LD;
          next_r.st = fast_mode_in ? scs_pkg::ST_CONV : scs_pkg::ST_WAKE;
        end
      end
      scs_pkg::ST_WAKE:
      begin
        if (step_end)
        begin
          next_r.step_cnt = STEP_LD;
          next_r.st = scs_pkg::ST_CONV;
        end
        else
          next_r.step_cnt = r.step_cnt - 1'b1;
      end
      scs_pkg::ST_CONV:
      begin
        if (step_end)
        begin
          next_r.step_cnt = STEP_LD;
          next_r.trial = kept | (r.mask >> 1);
          next_r.mask = r.mask >> 1;
          if (r.mask[0])
            next_r.st = scs_pkg::ST_DONE;
        end
        else
          next_r.step_cnt = r.step_cnt - 1'b1;
      end
      scs_pkg::ST_DONE:
      begin
        push = 1'b1;
        if (buf_ready)
        begin
          next_r.st = scs_pkg::ST_ACQ;
          next_r.first = ~r.fast;
        end
      end
      default:
        next_r.st = scs_pkg::ST_ACQ;
    endcase
    if (!ce_in)
    begin
      next_r = r;
      push = 1'b0;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      r <= '0;
      r.first <= 1'b1;
    end
    else
      r <= next_r;
  end
  // ****************************************
  // Result and outputs
  // ****************************************
  always_comb
  begin
    if (r.over)
      push_data.code = scs_pkg::CODE_FULL;
    else if (r.under)
      push_data.code = scs_pkg::CODE_ZERO;
    else
      push_data.code = r.trial;
    push_data.first = r.first & r.fast;
  end
  scs_buffer #(
    .WIDTH($bits(scs_pkg::scs_result_t)),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .in_valid_in(push),
    .in_ready_out(buf_ready),
    .in_data_in(push_data),
    .out_valid_out(result_valid_out),
    .out_ready_in(result_ready_in),
    .out_data_out(result_out)
  );
  assign busy_out = (r.st != scs_pkg::ST_ACQ);
  assign track_out = (r.st == scs_pkg::ST_ACQ);
  // Low-power mode sleeps in acquisition, fast mode stays up once a fast conversion is accepted
  assign power_up_out = r.fast | (r.st != scs_pkg::ST_ACQ);
  assign dac_code_out = r.trial;
  // ****************************************
  // Checks
  // ****************************************
  property p_start_busy;
    (accept && ce_in) |=> busy_out;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("accepted start did not raise busy");
  property p_msb_first;
    (accept && ce_in) |=> (r.mask == scs_pkg::CODE_MID && r.trial == scs_pkg::CODE_MID);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("conversion did not begin at the top bit");
  property p_halve;
    (r.st == scs_pkg::ST_CONV && step_end && !r.mask[0] && ce_in)
      |=> (r.mask == ($past(r.mask) >> 1));
  endproperty
  a_halve: assert property (p_halve)
    else $error("trial weight not halved");
  property p_return;
    (r.st == scs_pkg::ST_DONE && buf_ready && ce_in) |=> (track_out && !busy_out);
  endproperty
  a_return: assert property (p_return)
    else $error("no return to acquisition after last bit");
  property p_fast_time;
    disable iff (!rst_n_in || !ce_in)
    (accept && fast_mode_in) |-> ##[1:40] (r.st == scs_pkg::ST_DONE);
  endproperty
  a_fast_time: assert property (p_fast_time)
    else $error("fast conversion overran its period");
  property p_norm_time;
    disable iff (!rst_n_in || !ce_in)
    (accept && !fast_mode_in) |-> ##[1:50] (r.st == scs_pkg::ST_DONE);
  endproperty
  a_norm_time: assert property (p_norm_time)
    else $error("low-power conversion overran its period");
  property p_norm_sleep;
    (track_out && !r.fast) |-> !power_up_out;
  endproperty
  a_norm_sleep: assert property (p_norm_sleep)
    else $error("low-power mode stayed powered between conversions");
  property p_clamp_high;
    (push && r.over) |-> (push_data.code == scs_pkg::CODE_FULL);
  endproperty
  a_clamp_high: assert property (p_clamp_high)
    else $error("overrange result not saturated high");
  property p_clamp_low;
    (push && r.under && !r.over) |-> (push_data.code == scs_pkg::CODE_ZERO);
  endproperty
  a_clamp_low: assert property (p_clamp_low)
    else $error("underrange result not saturated low");
  c_fast_done: cover property (r.st == scs_pkg::ST_DONE && r.fast);
  c_norm_done: cover property (r.st == scs_pkg::ST_DONE && !r.fast);
  c_stall: cover property (push && !buf_ready);
  c_clamp: cover property (push && (r.over || r.under));
endmodule
`default_nettype wire

// [tb_scs_sequencer.sv]
/*
  Self-checking bench of the conversion sequencer.
  Assumes the analog model answers trial codes at once.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_scs_sequencer;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic convert_start = 1'b0;
  logic fast = 1'b0;
  logic over = 1'b0;
  logic under = 1'b0;
  logic rdy = 1'b1;
  logic [15:0] vin = 16'h0000;
  logic ce = 1'b1;
  logic trk;
  logic comp;
  logic busy;
  logic pwr;
  logic rv;
  logic [15:0] dac;
  scs_pkg::scs_result_t res;
  int n_fail = 0;
  int n_checks = 0;
  always #5 clk_in = ~clk_in;
  scs_analog_model i_ana (.vin_in(vin), .dac_code_in(dac), .comp_out(comp));
  scs_sequencer i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
    .convert_start_in(convert_start), .fast_mode_in(fast), .comp_in(comp),
    .over_range_in(over), .under_range_in(under), .result_ready_in(rdy),
    .busy_out(busy), .power_up_out(pwr), .track_out(trk), .dac_code_out(dac),
    .result_valid_out(rv), .result_out(res));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic stop_test();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic cyc();
    @(posedge clk_in);
    #1;
  endtask
  task automatic wt(input logic lvl, input logic is_busy);
    int i;
    i = 0;
    while ((is_busy ? busy : rv) !== lvl && i < 1000)
    begin
      cyc();
      i++;
    end
    if (i == 1000)
    begin
      check(1'b0, "wait timeout");
      stop_test();
    end
  endtask
  task automatic start(input logic [15:0] v);
    repeat (60) cyc();
    vin = v;
    convert_start = 1'b1;
    cyc();
    convert_start = 1'b0;
  endtask
  task automatic conv(input logic [15:0] v);
    start(v);
    wt(1'b1, 1'b1);
    wt(1'b0, 1'b1);
  endtask
  task automatic take(input logic [15:0] c, input logic f);
    wt(1'b1, 1'b0);
    check(res.code === c, "result code");
    check(res.first === f, "first flag");
    cyc();
  endtask
  task automatic rst(input logic f);
    rst_n_in = 1'b0;
    fast = f;
    repeat (10) cyc();
    rst_n_in = 1'b1;
    repeat (2) cyc();
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_low();
    conv(16'h2468);
    take(16'h2468, 1'b0);
    check(pwr === 1'b0, "powered while idle");
    check(trk === 1'b1, "not back in acquisition");
    $display("done low power");
  endtask
  task automatic t_codes();
    logic [15:0] tbl [7];
    tbl = '{16'h0000, 16'h0001, 16'h7FFF, 16'h8000, 16'h8001, 16'hFFFE, 16'hFFFF};
    foreach (tbl[k])
    begin
      conv(tbl[k]);
      take(tbl[k], 1'b0);
    end
    $display("done codes");
  endtask
  task automatic t_range();
    over = 1'b1;
    conv(16'h1234);
    take(scs_pkg::CODE_FULL, 1'b0);
    over = 1'b0;
    under = 1'b1;
    conv(16'h5678);
    take(scs_pkg::CODE_ZERO, 1'b0);
    under = 1'b0;
    $display("done range");
  endtask
  task automatic t_hold();
    logic [15:0] held;
    start(16'h3C3C);
    repeat (15) cyc();
    ce = 1'b0;
    held = dac;
    repeat (20) cyc();
    check(busy === 1'b1 && pwr === 1'b1 && dac === held, "state moved while frozen");
    ce = 1'b1;
    wt(1'b0, 1'b1);
    take(16'h3C3C, 1'b0);
    $display("done hold");
  endtask
  task automatic t_buf();
    rdy = 1'b0;
    conv(16'hA5A5);
    conv(16'h5A5A);
    check(rv === 1'b1, "held result lost");
    start(16'h0F0F);
    repeat (60) cyc();
    check(busy === 1'b1, "third result not held back");
    rdy = 1'b1;
    take(16'hA5A5, 1'b0);
    take(16'h5A5A, 1'b0);
    take(16'h0F0F, 1'b0);
    check(rv === 1'b0, "buffer not empty");
    $display("done buffer");
  endtask
  task automatic t_fast();
    rst(1'b1);
    conv(16'h4321);
    take(16'h4321, 1'b1);
    conv(16'h1357);
    take(16'h1357, 1'b0);
    check(pwr === 1'b1, "powered down while idle");
    $display("done fast");
  endtask
  initial
  begin
    rst(1'b0);
    t_low();
    t_codes();
    t_range();
    t_hold();
    t_buf();
    t_fast();
    stop_test();
  end
endmodule
`default_nettype wire
